// ===== hdl/fbh_bus_cycle.sv
// One asynchronous flash bus cycle, read or write, on the flash pins.
// Assumes the flash data bus is sampled across domains: it passes two
// flip-flops before the captured read value is taken.
`timescale 1ns/10ps
module fbh_bus_cycle (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic is_read,
   input wire logic [fbh_pkg::FA_W-1:0] addr,
   input wire logic [15:0] wdata,
   output logic done,
   output logic [15:0] rdata,
   output logic [fbh_pkg::FA_W-1:0] flash_addr,
   output logic [15:0] flash_dq_o,
   output logic flash_dq_oe,
   input wire logic [15:0] flash_dq_i,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n
);
   import fbh_pkg::*;

   fbh_cyc_e st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic rd_q, rd_d;
   logic [FA_W-1:0] addr_q, addr_d;
   logic [15:0] wd_q, wd_d, rdata_q, rdata_d;
   logic [15:0] dq_s1_q, dq_s2_q;

   // ****************************************
   // Cycle sequencer
   // ****************************************
   // Next state of the cycle; strobe timing counts down per phase
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      rd_d = rd_q;
      addr_d = addr_q;
      wd_d = wd_q;
      rdata_d = rdata_q;
      done = 1'b0;
      case (st_q)
         CY_IDLE: begin
            if (start) begin
               st_d = CY_SETUP;
               cnt_d = CNT_W'(SETUP_CYC);
               rd_d = is_read;
               addr_d = addr;
               wd_d = wdata;
            end
         end
         CY_SETUP: begin
            if (cnt_q <= CNT_W'(1)) begin
               st_d = CY_PULSE;
               cnt_d = rd_q ? CNT_W'(RPULSE_CYC) : CNT_W'(WPULSE_CYC);
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         CY_PULSE: begin
            if (cnt_q <= CNT_W'(1)) begin
               st_d = CY_RECOV;
               cnt_d = CNT_W'(RECOV_CYC);
               // Access time covers the two synchroniser stages
               if (rd_q) begin
                  rdata_d = dq_s2_q;
               end
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         CY_RECOV: begin
            if (cnt_q <= CNT_W'(1)) begin
               st_d = CY_IDLE;
               done = 1'b1;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         default: st_d = CY_IDLE;
      endcase
   end

   // Registers of the cycle and the data bus synchroniser
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= CY_IDLE;
         cnt_q <= '0;
         rd_q <= 1'b0;
         addr_q <= '0;
         wd_q <= '0;
         rdata_q <= '0;
         dq_s1_q <= '0;
         dq_s2_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         rd_q <= rd_d;
         addr_q <= addr_d;
         wd_q <= wd_d;
         rdata_q <= rdata_d;
         dq_s1_q <= flash_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   // Chip select spans the cycle; the strobe only the pulse phase.
   // Data is driven from setup through recovery so that it stands well
   // around the rising write strobe where the flash latches it.
   assign flash_addr = addr_q;
   assign flash_dq_o = wd_q;
   assign flash_dq_oe = (st_q != CY_IDLE) && !rd_q;
   assign flash_ce_n = (st_q == CY_IDLE);
   assign flash_we_n = !((st_q == CY_PULSE) && !rd_q);
   assign flash_oe_n = !((st_q == CY_PULSE) && rd_q);
   assign rdata = rdata_q;

   // write data held at strobe rise
   wdata_at_latch_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n && $stable(flash_dq_o))
      else $error("write data not held as write strobe rises");

   strobe_exclusive_a: assert property (@(posedge core_clk) disable iff (rst)
      !(!flash_we_n && !flash_oe_n) && (flash_we_n || flash_dq_oe))
      else $error("read and write strobes overlap");
endmodule

// ===== hdl/fbh_host.sv
// Flash bank command host: Avalon-MM orders become flash read and command cycles.
// Assumes flash pins wired straight to the device, an asynchronous ready pin and
// software flagging a bank that is erase-suspended.
// What this block does
// - Host writes command cycles in order; OP_WRITE issues any software address and data.
// - Leave autoselect by reset, back to prior mode.
// - On timeout flag, host writes reset.
// - Autoselect is two unlocks plus bank command.
// - Protection read needs bank and sector address.
// - Query entry is 98h at 55h when ready.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
module fbh_host (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [fbh_pkg::FA_W-1:0] flash_addr,
   output logic [15:0] flash_dq_o,
   output logic flash_dq_oe,
   input wire logic [15:0] flash_dq_i,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_byte_n,
   output logic flash_reset_n,
   input wire logic flash_ready
);
   import fbh_pkg::*;
   // ****************************************
   // State
   // ****************************************
   fbh_seq_e sq_q, sq_d;
   fbh_op_e op_q, op_d;
   fbh_mode_e mode_q, mode_d;
   logic [1:0] step_q, step_d;
   logic [FA_W-1:0] addr_q, addr_d, cyc_addr, cyc_addr_word;
   logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d, cyc_wdata, cyc_rdata;
   logic byte_q, byte_d, susp_q, susp_d, hwrst_q, hwrst_d;
   logic refused_q, refused_d, tmo_q, tmo_d, rd_pend_q, rd_pend_d, rdy_s1_q, rdy_s2_q;
   logic [31:0] rdbus_q, rdbus_d, status_word;
   logic cyc_start, cyc_done, cyc_read, cyc_last, wr_take, go_take;
   // ****************************************
   // Command step table
   // ****************************************
   // Address, data and direction of each bus cycle of the current order
   always_comb begin
      cyc_read = 1'b0;
      cyc_last = 1'b1;
      cyc_addr_word = addr_q;
      cyc_wdata = wdata_q;
      case (op_q)
         OP_RESET: begin
            cyc_addr_word = '0;
            cyc_wdata = RESET_CMD;
         end
         OP_AUTOSEL: begin
            cyc_last = (step_q == 2'h2);
            case (step_q)
               2'h0: begin
                  cyc_addr_word = UNLOCK1_ADDR;
                  cyc_wdata = UNLOCK1_DATA;
               end
               2'h1: begin
                  cyc_addr_word = UNLOCK2_ADDR;
                  cyc_wdata = UNLOCK2_DATA;
               end
               // bank and sector bits ride on the address
               default: begin
                  cyc_addr_word = addr_q | UNLOCK1_ADDR;
                  cyc_wdata = AUTOSEL_CMD;
               end
            endcase
         end
         OP_QUERY: begin
            cyc_addr_word = QUERY_ADDR;
            cyc_wdata = QUERY_CMD;
         end
         OP_READ, OP_POLL: cyc_read = 1'b1;
         default: ;
      endcase
   end
   assign cyc_addr = byte_q ? {cyc_addr_word[FA_W-2:0], 1'b0} : cyc_addr_word;
   // ****************************************
   // Avalon slave
   // ****************************************
   // Reads take one wait state so read data comes from a register;
   // a new order stalls while one is in progress.
   assign go_take = avs_write && (avs_address == REG_CTRL) && avs_writedata[CTRL_GO_BIT];
   assign avs_waitrequest = (avs_read && !rd_pend_q) || (go_take && (sq_q != SQ_IDLE));
   assign wr_take = avs_write && !avs_waitrequest;
   assign avs_readdata = rdbus_q;
   // Bit 3 is spare so the sticky flags sit at their mapped positions
   assign status_word = {25'h0, rdy_s2_q, tmo_q, refused_q, 1'b0, mode_q, sq_q != SQ_IDLE};
   // ****************************************
   // Sequencer and registers, next values
   // ****************************************
   always_comb begin
      sq_d = sq_q;
      op_d = op_q;
      mode_d = mode_q;
      step_d = step_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      byte_d = byte_q;
      susp_d = susp_q;
      hwrst_d = hwrst_q;
      refused_d = refused_q;
      tmo_d = tmo_q;
      rd_pend_d = avs_read && !rd_pend_q;
      rdbus_d = rdbus_q;
      cyc_start = 1'b0;
      if (avs_read && !rd_pend_q) begin
         case (avs_address)
            REG_CTRL: rdbus_d = {21'h0, hwrst_q, susp_q, byte_q, 5'h0, op_q};
            REG_ADDR: rdbus_d = {{(32-FA_W){1'b0}}, addr_q};
            REG_WDATA: rdbus_d = {16'h0, wdata_q};
            REG_RDATA: rdbus_d = {16'h0, rdata_q};
            REG_STATUS: rdbus_d = status_word;
            default: rdbus_d = '0;
         endcase
      end
      // Software clears sticky flags by writing one; a new event wins below
      if (wr_take) begin
         case (avs_address)
            REG_ADDR: addr_d = avs_writedata[FA_W-1:0];
            REG_WDATA: wdata_d = avs_writedata[15:0];
            REG_STATUS: begin
               if (avs_writedata[ST_REFUSED_BIT]) refused_d = 1'b0;
               if (avs_writedata[ST_TMO_BIT]) tmo_d = 1'b0;
            end
            default: ;
         endcase
      end
      case (sq_q)
         SQ_IDLE: begin
            if (wr_take && (avs_address == REG_CTRL)) begin
               byte_d = avs_writedata[CTRL_BYTE_BIT];
               susp_d = avs_writedata[CTRL_SUSP_BIT];
               hwrst_d = avs_writedata[CTRL_HWRST_BIT];
               if (avs_writedata[CTRL_GO_BIT]) begin
                  op_d = fbh_op_e'(avs_writedata[CTRL_OP_LSB +: 3]);
                  step_d = '0;
                  // no mode entry while the device is busy
                  if (((op_d == OP_AUTOSEL) || (op_d == OP_QUERY)) && !rdy_s2_q) begin
                     refused_d = 1'b1;
                  end else begin
                     sq_d = SQ_ISSUE;
                  end
               end
               // A hardware reset puts every bank back in read mode
               if (avs_writedata[CTRL_HWRST_BIT]) mode_d = MD_READ;
            end
         end
         SQ_ISSUE: begin
            cyc_start = 1'b1;
            sq_d = SQ_WAIT;
         end
         SQ_WAIT: begin
            if (cyc_done) begin
               sq_d = SQ_NEXT;
               if (cyc_read) rdata_d = cyc_rdata;
            end
         end
         SQ_NEXT: begin
            sq_d = SQ_IDLE;
            // timeout flag answered with a reset
            if ((op_q == OP_POLL) && rdata_q[TIMEOUT_BIT]) begin
               tmo_d = 1'b1;
               op_d = OP_RESET;
               sq_d = SQ_ISSUE;
            end else if (!cyc_last) begin
               step_d = step_q + 2'h1;
               sq_d = SQ_ISSUE;
            end else begin
               case (op_q)
                  // reset returns to the prior read mode
                  OP_RESET: mode_d = susp_q ? MD_SUSP_READ : MD_READ;
                  OP_AUTOSEL: mode_d = MD_AUTOSEL;
                  OP_QUERY: mode_d = MD_QUERY;
                  default: ;
               endcase
            end
         end
         default: sq_d = SQ_IDLE;
      endcase
   end
   // Register stage; ready pin passes a two flip-flop synchroniser
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sq_q <= SQ_IDLE;
         op_q <= OP_RESET;
         mode_q <= MD_READ;
         step_q <= '0;
         addr_q <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         byte_q <= 1'b0;
         susp_q <= 1'b0;
         hwrst_q <= 1'b0;
         refused_q <= 1'b0;
         tmo_q <= 1'b0;
         rd_pend_q <= 1'b0;
         rdbus_q <= '0;
         rdy_s1_q <= 1'b0;
         rdy_s2_q <= 1'b0;
      end else begin
         sq_q <= sq_d;
         op_q <= op_d;
         mode_q <= mode_d;
         step_q <= step_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         byte_q <= byte_d;
         susp_q <= susp_d;
         hwrst_q <= hwrst_d;
         refused_q <= refused_d;
         tmo_q <= tmo_d;
         rd_pend_q <= rd_pend_d;
         rdbus_q <= rdbus_d;
         rdy_s1_q <= flash_ready;
         rdy_s2_q <= rdy_s1_q;
      end
   end
   // Byte mode and hardware reset pins follow the control register
   assign flash_byte_n = !byte_q;
   assign flash_reset_n = !hwrst_q;
   // ****************************************
   // Pin cycle engine
   // ****************************************
   fbh_bus_cycle u_cycle (
      .core_clk(core_clk),
      .rst(rst),
      .start(cyc_start),
      .is_read(cyc_read),
      .addr(cyc_addr),
      .wdata(cyc_wdata),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .flash_addr(flash_addr),
      .flash_dq_o(flash_dq_o),
      .flash_dq_oe(flash_dq_oe),
      .flash_dq_i(flash_dq_i),
      .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n)
   );
   // ****************************************
   // Checks
   // ****************************************
   autosel_third_a: assert property (@(posedge core_clk) disable iff (rst)
      (cyc_start && op_q == OP_AUTOSEL && step_q == 2'h2) |-> cyc_wdata == AUTOSEL_CMD && cyc_last)
      else $error("autoselect command not on third cycle");
   query_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      (cyc_start && op_q == OP_QUERY) |->
      cyc_wdata == QUERY_CMD && cyc_addr == (byte_q ? {QUERY_ADDR[FA_W-2:0], 1'b0} : QUERY_ADDR))
      else $error("query entry cycle wrong");
   busy_refuse_a: assert property (@(posedge core_clk) disable iff (rst)
      (sq_q == SQ_IDLE && wr_take && go_take && !rdy_s2_q
       && (avs_writedata[2:0] == OP_AUTOSEL || avs_writedata[2:0] == OP_QUERY)) |=> sq_q == SQ_IDLE && refused_q)
      else $error("mode entry not refused while busy");
   reset_mode_a: assert property (@(posedge core_clk) disable iff (rst)
      (sq_q == SQ_NEXT && op_q == OP_RESET && cyc_last) |=> mode_q == (susp_q ? MD_SUSP_READ : MD_READ))
      else $error("reset did not restore read mode");
   timeout_reset_a: assert property (@(posedge core_clk) disable iff (rst)
      (sq_q == SQ_NEXT && op_q == OP_POLL && rdata_q[TIMEOUT_BIT])
      |=> sq_q == SQ_ISSUE && op_q == OP_RESET ##1 cyc_wdata == RESET_CMD)
      else $error("timeout flag not answered by reset");
   sticky_set_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(tmo_q) |-> $past(sq_q) == SQ_NEXT)
      else $error("timeout flag set without a poll");
endmodule

// ===== hdl/fbh_pkg.sv
// Package for the flash bank command host: register map, command codes,
// flash cycle timing and state encodings.
// Assumes a 200 MHz core clock and an x16 parallel flash with byte mode.
package fbh_pkg;
   // ****************************************
   // Clock and flash bus timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int T_SETUP_NS = 10;   // Address and select before strobe
   localparam int T_WPULSE_NS = 35;  // Write strobe low time
   localparam int T_RPULSE_NS = 70;  // Read access with strobe low
   localparam int T_RECOV_NS = 20;   // Strobe high before next cycle
   // Least times round up to whole cycles
   localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WPULSE_CYC = (T_WPULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RPULSE_CYC = (T_RPULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECOV_CYC = (T_RECOV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 5;

   // ****************************************
   // Flash command set
   // ****************************************
   localparam int FA_W = 22;
   localparam logic [FA_W-1:0] UNLOCK1_ADDR = 22'h000555;
   localparam logic [FA_W-1:0] UNLOCK2_ADDR = 22'h0002aa;
   localparam logic [FA_W-1:0] QUERY_ADDR = 22'h000055;
   localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
   localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
   localparam logic [15:0] AUTOSEL_CMD = 16'h0090;
   localparam logic [15:0] QUERY_CMD = 16'h0098;
   localparam logic [15:0] RESET_CMD = 16'h00f0;
   localparam int TIMEOUT_BIT = 5;

   // ****************************************
   // Software register map (word index on the Avalon port)
   // ****************************************
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_ADDR = 3'h1;
   localparam logic [2:0] REG_WDATA = 3'h2;
   localparam logic [2:0] REG_RDATA = 3'h3;
   localparam logic [2:0] REG_STATUS = 3'h4;
   // CTRL fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_GO_BIT = 3;
   localparam int CTRL_BYTE_BIT = 8;
   localparam int CTRL_SUSP_BIT = 9;
   localparam int CTRL_HWRST_BIT = 10;
   // STATUS fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_MODE_LSB = 1;
   localparam int ST_REFUSED_BIT = 4;
   localparam int ST_TMO_BIT = 5;
   localparam int ST_READY_BIT = 6;

   typedef enum logic [2:0] {
      OP_RESET = 3'h0,
      OP_AUTOSEL = 3'h1,
      OP_QUERY = 3'h2,
      OP_READ = 3'h3,
      OP_WRITE = 3'h4,
      OP_POLL = 3'h5
   } fbh_op_e;

   // Expected mode of the addressed bank
   typedef enum logic [1:0] {
      MD_READ = 2'h0,
      MD_SUSP_READ = 2'h1,
      MD_AUTOSEL = 2'h2,
      MD_QUERY = 2'h3
   } fbh_mode_e;

   // Gray coded along idle, issue, wait, next
   typedef enum logic [1:0] {
      SQ_IDLE = 2'b00,
      SQ_ISSUE = 2'b01,
      SQ_WAIT = 2'b11,
      SQ_NEXT = 2'b10
   } fbh_seq_e;

   // Gray coded along idle, setup, pulse, recover
   typedef enum logic [1:0] {
      CY_IDLE = 2'b00,
      CY_SETUP = 2'b01,
      CY_PULSE = 2'b11,
      CY_RECOV = 2'b10
   } fbh_cyc_e;
endpackage

// ===== tb/fbh_flash_model.sv
// Behavioural flash device facing the command host.
// Assumes the bench drives busy, timeout and suspend in place of the
// embedded operations that this model leaves out.
`timescale 1ns/10ps
module fbh_flash_model (
   input wire logic [21:0] flash_addr,
   input wire logic [15:0] host_dq,
   input wire logic host_dq_oe,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_byte_n,
   input wire logic flash_reset_n,
   input wire logic busy,
   input wire logic tmo,
   input wire logic susp,
   output logic [15:0] dq,
   output logic flash_ready
);
   import fbh_pkg::*;
   localparam logic [15:0] CODE = 16'h1234; // Arbitrary autoselect code
   fbh_mode_e mode_q = MD_READ;
   logic [1:0] ucnt = 0;
   logic [21:0] la;
   logic [15:0] ld;
   logic [15:0] val;
   logic [15:0] last = 0;
   int resets = 0;
   wire wr_n = flash_we_n | flash_ce_n;
   wire rd = !flash_ce_n && !flash_oe_n;
   wire [21:0] wa = flash_byte_n ? flash_addr : flash_addr >> 1;
   function automatic logic [15:0] qtable(input logic [7:0] a);
      case (a)
         8'h40: return 16'h0050;
         8'h41: return 16'h0052;
         8'h42: return 16'h0049;
         8'h43: return 16'h0031;
         8'h44: return 16'h0033;
         8'h45: return 16'h000c;
         8'h46: return 16'h0002;
         8'h47, 8'h48: return 16'h0001;
         8'h49: return 16'h0004;
         8'h4a: return 16'h0038;
         8'h4d: return 16'h0085;
         8'h4e: return 16'h0095;
         8'h4f: return 16'h0002; // Bottom boot variant
         8'h57: return 16'h0004; // Four banks
         8'h58: return 16'h000f;
         8'h59, 8'h5a: return 16'h0018;
         8'h5b: return 16'h0008;
         default: return 16'h0000; // Unsupported features read zero
      endcase
   endfunction
   always @(negedge wr_n) la = wa;
   always @(posedge wr_n or negedge flash_reset_n) begin
      if (!flash_reset_n) begin
         mode_q = MD_READ;
         ucnt = 0;
      end else begin
         ld = host_dq;
         if (ld[7:0] == 8'hf0) begin
            resets++;
            // Ignored while erasing unless the timeout flag is up
            if (!busy || tmo) mode_q = susp ? MD_SUSP_READ : MD_READ;
         end else if (ucnt == 2 && la[10:0] == 11'h555 && ld[7:0] == 8'h90 && !busy) begin
            mode_q = MD_AUTOSEL;
         end else if (la == 22'h55 && ld[7:0] == 8'h98 && !busy) begin
            mode_q = MD_QUERY;
         end
         ucnt = (la[10:0] == 11'h555 && ld[7:0] == 8'haa) ? 2'd1 :
                (ucnt == 1 && la[10:0] == 11'h2aa && ld[7:0] == 8'h55) ? 2'd2 : 2'd0;
      end
   end
   // read data by mode; a released bus shows the inverse, not a stale value
   // in suspend-read the first sector stands for the suspended one and reads status
   assign val = tmo ? 16'h0020 : mode_q == MD_QUERY ? qtable(wa[7:0]) :
                mode_q == MD_AUTOSEL ? CODE :
                (mode_q == MD_SUSP_READ && wa[21:11] == 11'h0) ? 16'h0040 : wa[15:0] ^ 16'h5a5a;
   always @(negedge rd) last = val;
   assign dq = host_dq_oe ? host_dq : rd ? val : ~last;
   assign flash_ready = !busy;
endmodule

// ===== tb/tb.sv
// Self-checking bench for the flash command host.
// Assumes the behavioural flash model stands on the flash pins.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb;
   import fbh_pkg::*;
   logic core_clk = 0;
   logic rst = 1;
   logic [2:0] avs_address = 0;
   logic avs_read = 0;
   logic avs_write = 0;
   logic [31:0] avs_writedata = 0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [21:0] flash_addr;
   logic [15:0] flash_dq_o;
   logic [15:0] dq;
   logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_byte_n, flash_reset_n, flash_ready;
   logic busy = 0;
   logic tmo = 0;
   logic susp = 0;
   int errors = 0;
   int checks = 0;
   int r0;
   logic [31:0] seed = 78334;
   logic [31:0] q;
   logic [21:0] a;
   fbh_host i_fbh_host (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i(dq),
      .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_byte_n, .flash_reset_n, .flash_ready);
   fbh_flash_model i_fbh_flash_model (.flash_addr, .host_dq(flash_dq_o), .host_dq_oe(flash_dq_oe),
      .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_byte_n, .flash_reset_n, .busy, .tmo, .susp,
      .dq, .flash_ready);
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One Avalon transfer; held until waitrequest is sampled low
   task av(input logic wr, input logic [2:0] ad, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 5000);
      if (n >= 5000) begin
         errors++;
         give_verdict;
      end else begin
         q = avs_readdata;
         avs_write <= 0;
         avs_read <= 0;
      end
   endtask
   // Order an operation and poll until the host is idle again
   task op(input logic [2:0] o, input logic [21:0] ad, input logic bm);
      int n;
      av(1, REG_ADDR, 32'(ad));
      av(1, REG_CTRL, {21'h0, 1'b0, susp, bm, 4'h0, 1'b1, o});
      n = 0;
      do begin
         av(0, REG_STATUS, 0);
         n++;
      end while (q[ST_BUSY_BIT] !== 1'b0 && n < 200);
      if (n >= 200) begin
         errors++;
         give_verdict;
      end
   endtask
   task rdf(input logic [21:0] ad, input logic bm);
      op(OP_READ, ad, bm);
      av(0, REG_RDATA, 0);
   endtask
   // Host expectation and flash state must agree
   task modes(input fbh_mode_e e);
      av(0, REG_STATUS, 0);
      `CHK("status mode", 2'(e), q[ST_MODE_LSB +: 2])
      `CHK("flash mode", e, i_fbh_flash_model.mode_q)
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 0;
      modes(MD_READ);
      av(0, 3'h7, 0);
      `CHK("unmapped", 32'h0, q)
      repeat (4) begin
         a = 22'(xs());
         rdf(a, 0);
         `CHK("array", a[15:0] ^ 16'h5a5a, q[15:0])
      end
      r0 = xs();
      a = 22'(xs());
      av(1, REG_WDATA, {16'h0, 8'(r0), 8'h00});
      op(OP_WRITE, a, 0);
      `CHK("latched address", a, i_fbh_flash_model.la)
      `CHK("latched data", {8'(r0), 8'h00}, i_fbh_flash_model.ld)
      $display("test array done");
      for (int bm = 0; bm < 2; bm++) begin
         op(OP_QUERY, 0, bm[0]);
         modes(MD_QUERY);
         `CHK("byte pin", ~bm[0], flash_byte_n)
         for (int i = 'h40; i <= 'h5b; i++) begin
            rdf(22'(i), bm[0]);
            `CHK("query", i_fbh_flash_model.qtable(8'(i)), q[15:0])
         end
         op(OP_RESET, 0, bm[0]);
         modes(MD_READ);
      end
      $display("test query done");
      susp = 1;
      q = xs();
      a = {q[21:11], 11'h000};
      op(OP_AUTOSEL, a, 0);
      modes(MD_AUTOSEL);
      repeat (2) begin
         rdf(a | 22'h2, 0);
         `CHK("code", i_fbh_flash_model.CODE, q[15:0])
      end
      op(OP_RESET, 0, 0);
      modes(MD_SUSP_READ);
      rdf(22'h000123, 0);
      `CHK("suspended sector", 16'h0040, q[15:0])
      rdf(22'h000923, 0);
      `CHK("other sector", 16'h0923 ^ 16'h5a5a, q[15:0])
      susp = 0;
      op(OP_RESET, 0, 0);
      modes(MD_READ);
      $display("test autoselect done");
      busy <= 1;
      repeat (4) @(posedge core_clk);
      for (int k = 1; k <= 2; k++) begin
         op(3'(k), 22'h0, 0);
         av(0, REG_STATUS, 0);
         `CHK("refused", 1'b1, q[ST_REFUSED_BIT])
         `CHK("ready", 1'b0, q[ST_READY_BIT])
         modes(MD_READ);
         av(1, REG_STATUS, 32'h10);
      end
      $display("test refusal done");
      tmo <= 1;
      r0 = i_fbh_flash_model.resets;
      op(OP_POLL, a, 0);
      av(0, REG_STATUS, 0);
      `CHK("timeout flag", 1'b1, q[ST_TMO_BIT])
      `CHK("reset count", r0 + 1, i_fbh_flash_model.resets)
      tmo <= 0;
      busy <= 0;
      repeat (4) @(posedge core_clk);
      op(OP_QUERY, 0, 0);
      av(1, REG_CTRL, 32'h400);
      av(0, REG_STATUS, 0);
      `CHK("reset pin", 1'b0, flash_reset_n)
      av(1, REG_CTRL, 0);
      modes(MD_READ);
      $display("test reset done");
      give_verdict;
   end
endmodule
